// ### payload_map_pkg.sv
// Purpose: shared constants, field layouts and types of the payload mapping block
// Assumes: AXI4-Lite with 8-bit byte addresses and 32-bit data
// Notes: every register takes one aligned word; unused bits read as zero

package payload_map_pkg;

  // ----------------------------------------------------------------
  // register map
  // ----------------------------------------------------------------
  localparam logic [7:0] OFS_PORT_CONTROL_ONE = 8'h00;
  localparam logic [7:0] OFS_PORT_CONTROL_TWO = 8'h04;
  localparam logic [7:0] OFS_LINE_CONTROL = 8'h08;
  localparam logic [7:0] OFS_FRACTION_SECTION_A = 8'h0C;
  localparam logic [7:0] OFS_FRACTION_GROUP = 8'h10;
  localparam logic [7:0] OFS_OVERHEAD_PATTERN = 8'h14;
  localparam logic [7:0] OFS_MAP_STATUS = 8'h18;
  localparam logic [7:0] OFS_VIOLATION_COUNT = 8'h1C;

  // ----------------------------------------------------------------
  // field positions
  // ----------------------------------------------------------------
  localparam int CAS_BIT = 0;        // cell_alignment_select
  localparam int HDLC_BIT = 1;       // 1: packets, 0: cells
  localparam int M23_PAYLOAD_BIT = 2; // M23 with C-bits carried as payload
  localparam int MODE_LSB = 0;       // framing_mode_select[5:0]
  localparam int UNI_BIT = 8;        // line_code_uni_select
  localparam int TX_ZSO_BIT = 0;     // tx_line_zero_suppress_off
  localparam int RX_ZSO_BIT = 1;     // rx_line_zero_suppress_off
  localparam int FRAC_OH_BIT = 0;    // section A is overhead
  localparam int FRAC_SIZE_LSB = 8;  // tx_fraction_section_a_size[7:0]
  localparam int ST_CELL_LSB = 0;
  localparam int ST_FRAME_LSB = 2;
  localparam int ST_TX_LSB = 4;
  localparam int ST_RX_LSB = 6;
  localparam int ST_PLCP_BIT = 8;
  localparam int ST_ERR_BIT = 9;

  // ----------------------------------------------------------------
  // framing mode decode and mapping constants
  // ----------------------------------------------------------------
  localparam logic [1:0] FAM_CBIT = 2'h0;
  localparam logic [1:0] FAM_M23 = 2'h1;
  localparam logic [1:0] FAM_G751 = 2'h2;
  localparam logic [1:0] FAM_G832 = 2'h3;
  localparam logic [2:0] SUB_MASK = 3'h1;
  localparam logic [2:0] SUB_IFRAC = 3'h2;
  localparam logic [2:0] SUB_OCTET_MASK = 3'h3;
  localparam logic [2:0] SUB_PLCP_MASK = 3'h5;
  localparam logic [1:0] SUB_PLCP_HI = 2'h2; // sub codes 100 and 101
  localparam logic [10:0] E3_OH_FIRST = 11'h00D; // frame bit 13
  localparam logic [10:0] E3_OH_LAST = 11'h010;  // frame bit 16
  localparam logic [3:0] PLCP_E3_PATTERN = 4'hC; // 1100
  localparam logic [3:0] ALT_PATTERN = 4'hA;     // 1010
  localparam logic [3:0] ONES_PATTERN = 4'hF;
  localparam logic [3:0] ZEROS_PATTERN = 4'h0;
  localparam logic [1:0] PAT_ONES = 2'h0;
  localparam logic [1:0] PAT_ZEROS = 2'h1;
  localparam logic [1:0] PAT_ALT = 2'h2;
  localparam logic [7:0] FRAC_OH_SIZE = 8'h04;
  localparam logic [15:0] G751_PAYLOAD_LEN = 16'h05F4; // 1524 bits
  localparam logic [15:0] COUNT_MAX = 16'hFFFF;
  localparam logic [1:0] RESP_OKAY = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;

  // ----------------------------------------------------------------
  // types
  // ----------------------------------------------------------------
  typedef enum logic [1:0] {
    ALIGN_BIT = 2'b00,
    ALIGN_NIBBLE = 2'b01,
    ALIGN_BYTE = 2'b10,
    ALIGN_CELL = 2'b11
  } align_e;

  typedef enum logic [1:0] {
    CODE_B3ZS = 2'b00,
    CODE_HDB3 = 2'b01,
    CODE_AMI = 2'b10,
    CODE_UNI = 2'b11
  } line_code_e;

  typedef struct packed {
    logic awvalid;
    logic [7:0] awaddr;
    logic wvalid;
    logic [31:0] wdata;
    logic [3:0] wstrb;
    logic bready;
    logic arvalid;
    logic [7:0] araddr;
    logic rready;
  } axil_req_s;

  typedef struct packed {
    logic awready;
    logic wready;
    logic bvalid;
    logic [1:0] bresp;
    logic arready;
    logic rvalid;
    logic [31:0] rdata;
    logic [1:0] rresp;
  } axil_rsp_s;

endpackage

// ### pin_sync.sv
// Purpose: brings the external pulse pin into the clk domain
// Assumes: pin pulses are wider than two clock periods
// Notes: rise is a one-cycle pulse, registered

`timescale 1ns/100ps

module pin_sync
(
  input wire logic clk,       // block clock
  input wire logic rst,       // synchronous reset, active high
  input wire logic pin_async, // raw pin
  output logic rise           // one pulse per rising edge of the pin
);

  logic meta_reg;
  logic sync_reg;
  logic last_reg;
  logic rise_next;

  // edge detect looks only at the second stage, never the first
  always_comb
  begin
    rise_next = sync_reg & ~last_reg;
  end

  // two-stage synchroniser plus edge history
  always_ff @(posedge clk)
  begin
    if (rst)
    begin
      meta_reg <= 1'b0;
      sync_reg <= 1'b0;
      last_reg <= 1'b0;
      rise <= 1'b0;
    end
    else
    begin
      meta_reg <= pin_async;
      sync_reg <= meta_reg;
      last_reg <= sync_reg;
      rise <= rise_next;
    end
  end

endmodule

// ### event_counter.sv
// Purpose: saturating 16-bit event counter with clear
// Assumes: inc and clr come from the clk domain
// Notes: an event in the clearing cycle is kept as a count of one

`timescale 1ns/100ps

module event_counter
  import payload_map_pkg::*;
(
  input wire logic clk,      // block clock
  input wire logic rst,      // synchronous reset, active high
  input wire logic inc,      // one count per cycle high
  input wire logic clr,      // clear pulse
  output logic [15:0] count  // registered count
);

  logic [15:0] count_next;

  // the clear wins, but an event in the clearing cycle counts as one so none is lost
  always_comb
  begin
    count_next = count;
    if (clr)
      count_next = inc ? 16'h0001 : 16'h0000;
    else if (inc && count != COUNT_MAX)
      count_next = count + 16'h0001;
  end

  always_ff @(posedge clk)
  begin
    if (rst)
      count <= 16'h0000;
    else
      count <= count_next;
  end

endmodule

// ### cell_packet_payload_mapping.sv
// Purpose: per-port payload mapping control: alignment, PLCP use, E3 overhead
//          bits, line code choice and violation counting, behind AXI4-Lite
// Assumes: frame_bit_index and decoder_violation come from the framer on clk
// Notes: outputs lag their causes by one clock
// Behaviour
// - DS3 direct: cells nibble or bit aligned as selected; packets bit aligned
// - PLCP frame inside DS3 frames always sits on nibble boundaries
// - DS3 PLCP: cells cell-aligned, no packets, alignment select ignored
// - DS3 PLCP only in C-bit or M23 frames with generated C-bits
// - E3 G.751 direct: cells and packets bit aligned
// - E3 PLCP: frame bits 13-16 forced 1100, PLCP byte aligned, select ignored
// - E3 PLCP only in G.751, cells cell-aligned, never packets
// - fractional overhead bits 13-16 filled with ones, zeros or 1010
// - G.751 internal fractional: cells and packets bit aligned, select ignored
// - G.832: cells byte or bit aligned as selected; packets always bit
// - UNI bypasses coding; violation counter may count external pin pulses
// - overhead-mask modes never count pin pulses
// - DS3 and 52M clear channel use B3ZS, E3 uses HDB3
// - UNI bit wins; else suppress-off clear gives B3ZS/HDB3, set gives AMI
// - six-bit framing mode chooses framing independent of line mode
//
// Our own choices: the AXI4-Lite register port and the address map.

`timescale 1ns/100ps

module cell_packet_payload_mapping
(
  input wire logic clk,                                  // 200 MHz clock
  input wire logic rst,                                  // sync reset, high
  input payload_map_pkg::axil_req_s axil_req,            // AXI4-Lite requests
  output payload_map_pkg::axil_rsp_s axil_rsp,           // AXI4-Lite answers
  input wire logic [10:0] frame_bit_index,               // 1-based frame bit
  input wire logic decoder_violation,                    // coding violation
  input wire logic rx_negative_rail_pin,                 // external pulse pin
  output payload_map_pkg::align_e cell_align_mode,       // cell alignment
  output payload_map_pkg::align_e plcp_frame_align,      // PLCP frame alignment
  output logic plcp_active,                              // PLCP mapping on
  output payload_map_pkg::line_code_e tx_line_code,      // transmit code
  output payload_map_pkg::line_code_e rx_line_code,      // receive code
  output logic overhead_force,                           // replace this bit
  output logic overhead_value,                           // value to send
  output logic config_error                              // unusable setting
);
  import payload_map_pkg::*;

  // ----------------------------------------------------------------
  // decode helpers
  // ----------------------------------------------------------------
  function automatic logic is_mask_mode(input logic [5:0] mode);
    if (mode[5])
      is_mask_mode = (mode[2:0] == SUB_MASK) || (mode[2:0] == SUB_OCTET_MASK);
    else
      is_mask_mode = (mode[2:0] == SUB_MASK) || (mode[2:0] == SUB_PLCP_MASK);
  endfunction

  function automatic line_code_e pick_code(input logic uni, input logic off,
                                           input logic e3);
    if (uni)
      pick_code = CODE_UNI;
    else if (off)
      pick_code = CODE_AMI;
    else
      pick_code = e3 ? CODE_HDB3 : CODE_B3ZS;
  endfunction

  function automatic logic [31:0] merge(input logic [31:0] old,
                                        input logic [31:0] data, input logic [3:0] strb);
    merge = old;
    for (int i = 0; i < 4; i++)
      if (strb[i])
        merge[i*8 +: 8] = data[i*8 +: 8];
  endfunction

  // ----------------------------------------------------------------
  // control registers and bus state
  // ----------------------------------------------------------------
  logic [31:0] ctrl_one_reg, ctrl_one_next;
  logic [31:0] ctrl_two_reg, ctrl_two_next;
  logic [31:0] line_reg, line_next;
  logic [31:0] frac_a_reg, frac_a_next;
  logic [31:0] frac_g_reg, frac_g_next;
  logic [31:0] pat_reg, pat_next;
  logic aw_have_reg, aw_have_next;
  logic w_have_reg, w_have_next;
  logic [7:0] awaddr_reg, awaddr_next;
  logic [31:0] wdata_reg, wdata_next;
  logic [3:0] wstrb_reg, wstrb_next;
  axil_rsp_s rsp_next;
  logic cnt_clr;
  logic [15:0] viol_count;
  logic [31:0] status_word;

  assign status_word = {22'h000000, config_error, plcp_active, rx_line_code, tx_line_code,
                        plcp_frame_align, cell_align_mode};

  // bus slave: write waits for both address and data, then answers
  always_comb
  begin
    ctrl_one_next = ctrl_one_reg;
    ctrl_two_next = ctrl_two_reg;
    line_next = line_reg;
    frac_a_next = frac_a_reg;
    frac_g_next = frac_g_reg;
    pat_next = pat_reg;
    aw_have_next = aw_have_reg;
    w_have_next = w_have_reg;
    awaddr_next = awaddr_reg;
    wdata_next = wdata_reg;
    wstrb_next = wstrb_reg;
    rsp_next = axil_rsp;
    cnt_clr = 1'b0;
    if (axil_req.awvalid && axil_rsp.awready)
    begin
      aw_have_next = 1'b1;
      awaddr_next = axil_req.awaddr;
    end
    if (axil_req.wvalid && axil_rsp.wready)
    begin
      w_have_next = 1'b1;
      wdata_next = axil_req.wdata;
      wstrb_next = axil_req.wstrb;
    end
    if (axil_rsp.bvalid && axil_req.bready)
      rsp_next.bvalid = 1'b0;
    if (aw_have_reg && w_have_reg && !axil_rsp.bvalid)
    begin
      aw_have_next = 1'b0;
      w_have_next = 1'b0;
      rsp_next.bvalid = 1'b1;
      rsp_next.bresp = RESP_OKAY;
      case (awaddr_reg)
        OFS_PORT_CONTROL_ONE: ctrl_one_next = merge(ctrl_one_reg, wdata_reg, wstrb_reg);
        OFS_PORT_CONTROL_TWO: ctrl_two_next = merge(ctrl_two_reg, wdata_reg, wstrb_reg);
        OFS_LINE_CONTROL: line_next = merge(line_reg, wdata_reg, wstrb_reg);
        OFS_FRACTION_SECTION_A: frac_a_next = merge(frac_a_reg, wdata_reg, wstrb_reg);
        OFS_FRACTION_GROUP: frac_g_next = merge(frac_g_reg, wdata_reg, wstrb_reg);
        OFS_OVERHEAD_PATTERN: pat_next = merge(pat_reg, wdata_reg, wstrb_reg);
        OFS_MAP_STATUS: rsp_next.bresp = RESP_OKAY; // read-only, write ignored
        OFS_VIOLATION_COUNT: cnt_clr = 1'b1;
        default: rsp_next.bresp = RESP_SLVERR;
      endcase
    end
    if (axil_rsp.rvalid && axil_req.rready)
      rsp_next.rvalid = 1'b0;
    if (axil_req.arvalid && axil_rsp.arready)
    begin
      rsp_next.rvalid = 1'b1;
      rsp_next.rresp = RESP_OKAY;
      case (axil_req.araddr)
        OFS_PORT_CONTROL_ONE: rsp_next.rdata = ctrl_one_reg;
        OFS_PORT_CONTROL_TWO: rsp_next.rdata = ctrl_two_reg;
        OFS_LINE_CONTROL: rsp_next.rdata = line_reg;
        OFS_FRACTION_SECTION_A: rsp_next.rdata = frac_a_reg;
        OFS_FRACTION_GROUP: rsp_next.rdata = frac_g_reg;
        OFS_OVERHEAD_PATTERN: rsp_next.rdata = pat_reg;
        OFS_MAP_STATUS: rsp_next.rdata = status_word;
        OFS_VIOLATION_COUNT: rsp_next.rdata = {16'h0000, viol_count};
        default:
        begin
          rsp_next.rdata = 32'h00000000;
          rsp_next.rresp = RESP_SLVERR;
        end
      endcase
    end
    rsp_next.awready = !aw_have_next && !rsp_next.bvalid;
    rsp_next.wready = !w_have_next && !rsp_next.bvalid;
    rsp_next.arready = !rsp_next.rvalid;
  end

  // masks keep unimplemented bits reading as zero
  always_ff @(posedge clk)
  begin
    if (rst)
    begin
      ctrl_one_reg <= 32'h00000000;
      ctrl_two_reg <= 32'h00000000;
      line_reg <= 32'h00000000;
      frac_a_reg <= 32'h00000000;
      frac_g_reg <= 32'h00000000;
      pat_reg <= 32'h00000000;
      aw_have_reg <= 1'b0;
      w_have_reg <= 1'b0;
      awaddr_reg <= 8'h00;
      wdata_reg <= 32'h00000000;
      wstrb_reg <= 4'h0;
      axil_rsp <= '0;
    end
    else
    begin
      ctrl_one_reg <= ctrl_one_next & 32'h00000007;
      ctrl_two_reg <= ctrl_two_next & 32'h0000013F;
      line_reg <= line_next & 32'h00000003;
      frac_a_reg <= frac_a_next & 32'h0000FF01;
      frac_g_reg <= frac_g_next & 32'h0000FFFF;
      pat_reg <= pat_next & 32'h00000003;
      aw_have_reg <= aw_have_next;
      w_have_reg <= w_have_next;
      awaddr_reg <= awaddr_next;
      wdata_reg <= wdata_next;
      wstrb_reg <= wstrb_next;
      axil_rsp <= rsp_next;
    end
  end

  // ----------------------------------------------------------------
  // mapping decisions
  // ----------------------------------------------------------------
  logic [5:0] mode_sel;
  logic cas, hdlc, m23_pay, uni, mask_mode, e3, clear_ch, plcp_req, plcp_ok, g751;
  logic [1:0] fam;
  logic [2:0] sub;
  logic frac_ok, oh_window;
  logic [1:0] oh_sel;
  logic [3:0] frac_pattern;
  align_e cell_next, frame_next;
  logic plcp_next, err_next, force_next, value_next;

  assign mode_sel = ctrl_two_reg[MODE_LSB +: 6];
  assign fam = mode_sel[4:3];
  assign sub = mode_sel[2:0];
  assign clear_ch = mode_sel[5];
  assign cas = ctrl_one_reg[CAS_BIT];
  assign hdlc = ctrl_one_reg[HDLC_BIT];
  assign m23_pay = ctrl_one_reg[M23_PAYLOAD_BIT];
  assign uni = ctrl_two_reg[UNI_BIT];
  assign mask_mode = is_mask_mode(mode_sel);
  assign e3 = mode_sel[4];
  assign g751 = !clear_ch && fam == FAM_G751;
  assign plcp_req = !clear_ch && sub[2:1] == SUB_PLCP_HI;
  // PLCP rides only C-bit, M23 with generated C-bits, or G.751
  assign plcp_ok = plcp_req && !hdlc && (fam == FAM_CBIT || fam == FAM_G751 ||
                   (fam == FAM_M23 && !m23_pay));
  assign frac_ok = frac_a_reg[FRAC_OH_BIT] &&
                   frac_a_reg[FRAC_SIZE_LSB +: 8] == FRAC_OH_SIZE;
  assign oh_window = frame_bit_index >= E3_OH_FIRST && frame_bit_index <= E3_OH_LAST;
  assign oh_sel = 2'(E3_OH_LAST - frame_bit_index);
  assign frac_pattern = pat_reg[1:0] == PAT_ONES ? ONES_PATTERN :
                        pat_reg[1:0] == PAT_ZEROS ? ZEROS_PATTERN : ALT_PATTERN;

  // alignment and overhead choice; the select bit is ignored where fixed
  always_comb
  begin
    cell_next = ALIGN_BIT;
    plcp_next = 1'b0;
    if (clear_ch)
      cell_next = (sub == SUB_OCTET_MASK) ? ALIGN_BYTE : ALIGN_BIT;
    else if (plcp_ok)
    begin
      cell_next = ALIGN_CELL;
      plcp_next = 1'b1;
    end
    else if (hdlc)
      cell_next = ALIGN_BIT;
    else if (fam == FAM_G751)
      cell_next = ALIGN_BIT;
    else if (fam == FAM_G832)
      cell_next = cas ? ALIGN_BIT : ALIGN_BYTE;
    else
      cell_next = cas ? ALIGN_BIT : ALIGN_NIBBLE;
    if (plcp_ok)
      frame_next = e3 ? ALIGN_BYTE : ALIGN_NIBBLE;
    else
      frame_next = cell_next;
    // settings that the far side must avoid are flagged, not repaired
    err_next = (plcp_req && !plcp_ok) ||
               (!clear_ch && fam == FAM_M23 && m23_pay && !hdlc && !cas) ||
               (g751 && sub == SUB_IFRAC &&
                (!frac_ok || frac_g_reg[15:0] < G751_PAYLOAD_LEN));
    force_next = 1'b0;
    value_next = 1'b0;
    if (g751 && oh_window && plcp_ok)
    begin
      force_next = 1'b1;
      value_next = PLCP_E3_PATTERN[oh_sel];
    end
    else if (g751 && oh_window && sub == SUB_IFRAC && frac_ok)
    begin
      force_next = 1'b1;
      value_next = frac_pattern[oh_sel];
    end
  end

  always_ff @(posedge clk)
  begin
    if (rst)
    begin
      cell_align_mode <= ALIGN_NIBBLE;
      plcp_frame_align <= ALIGN_NIBBLE;
      plcp_active <= 1'b0;
      tx_line_code <= CODE_B3ZS;
      rx_line_code <= CODE_B3ZS;
      overhead_force <= 1'b0;
      overhead_value <= 1'b0;
      config_error <= 1'b0;
    end
    else
    begin
      cell_align_mode <= cell_next;
      plcp_frame_align <= frame_next;
      plcp_active <= plcp_next;
      tx_line_code <= pick_code(uni, line_reg[TX_ZSO_BIT], e3);
      rx_line_code <= pick_code(uni, line_reg[RX_ZSO_BIT], e3);
      overhead_force <= force_next;
      overhead_value <= value_next;
      config_error <= err_next;
    end
  end

  // ----------------------------------------------------------------
  // violation counting
  // ----------------------------------------------------------------
  logic pin_rise;
  logic cnt_inc;

  pin_sync u_pin_sync (
    .clk(clk),
    .rst(rst),
    .pin_async(rx_negative_rail_pin),
    .rise(pin_rise)
  );

  // UNI counts pin pulses unless overhead-mask owns the pin
  assign cnt_inc = uni ? (pin_rise && !mask_mode) : decoder_violation;

  event_counter u_event_counter (
    .clk(clk),
    .rst(rst),
    .inc(cnt_inc),
    .clr(cnt_clr),
    .count(viol_count)
  );

  // ----------------------------------------------------------------
  // checks
  // ----------------------------------------------------------------
  default clocking cb @(posedge clk); endclocking
  default disable iff (rst);

  sequence e3_plcp_first;
    g751 && plcp_ok && frame_bit_index == E3_OH_FIRST;
  endsequence

  sequence e3_plcp_third;
    g751 && plcp_ok && frame_bit_index == E3_OH_FIRST + 11'h002;
  endsequence

  AST_UNI_CODE: assert property (uni |=> tx_line_code == CODE_UNI &&
    rx_line_code == CODE_UNI) else $error("UNI not selected");
  AST_AMI_CODE: assert property (!uni && line_reg[TX_ZSO_BIT] |=>
    tx_line_code == CODE_AMI) else $error("AMI not selected");
  AST_E3_HDB3: assert property (!uni && !line_reg[RX_ZSO_BIT] && e3 |=>
    rx_line_code == CODE_HDB3) else $error("HDB3 not selected");
  AST_HDLC_BIT: assert property (hdlc && !clear_ch |=> cell_align_mode == ALIGN_BIT)
    else $error("packets not bit aligned");
  AST_PLCP_CELL: assert property (plcp_ok |=> cell_align_mode == ALIGN_CELL &&
    plcp_active) else $error("PLCP cells not cell aligned");
  AST_DS3_PLCP_NIBBLE: assert property (plcp_ok && !e3 |=>
    plcp_frame_align == ALIGN_NIBBLE) else $error("DS3 PLCP not nibble aligned");
  AST_PLCP_M23_PAYLOAD: assert property (plcp_req && fam == FAM_M23 && m23_pay |=>
    !plcp_active && config_error) else $error("PLCP accepted in M23 payload mode");
  AST_G832_BYTE: assert property (!clear_ch && fam == FAM_G832 && !hdlc && !cas &&
    !plcp_req |=> cell_align_mode == ALIGN_BYTE) else $error("G.832 not byte aligned");
  AST_E3_PATTERN: assert property (e3_plcp_first |=> overhead_force && overhead_value)
    else $error("E3 PLCP bit 13 not one");
  AST_E3_PATTERN_LOW: assert property (e3_plcp_third |=> overhead_force &&
    !overhead_value) else $error("E3 PLCP bit 15 not zero");
  AST_MASK_NO_COUNT: assert property (uni && mask_mode && !cnt_clr |=>
    viol_count == $past(viol_count)) else $error("pin counted in overhead-mask mode");
  AST_UNI_COUNT: assert property (uni && !mask_mode && pin_rise && !cnt_clr &&
    viol_count != COUNT_MAX |=> viol_count == $past(viol_count) + 16'h0001)
    else $error("pin pulse not counted");

endmodule

// ### framer_model.sv
// Purpose: framer stand-in that feeds bit positions and coding violations
// Assumes: shares the clock of the mapping block
// Notes: frame kept short so the overhead bits recur often

`timescale 1ns/100ps

module framer_model
#(
  parameter int FRAME_BITS = 40
)
(
  input wire logic clk,                // block clock
  input wire logic rst,                // sync reset, high
  input wire logic viol_en,            // bench asks for violations
  output logic [10:0] frame_bit_index, // 1-based position
  output logic decoder_violation       // one count per cycle high
);
  // ----------------------------------------------------------------
  // frame position and violation feed
  // ----------------------------------------------------------------
  // wrap at frame end so bits 13 to 16 come back every frame
  always_ff @(posedge clk)
  begin
    if (rst || frame_bit_index == 11'(FRAME_BITS))
      frame_bit_index <= 11'h001;
    else
      frame_bit_index <= frame_bit_index + 11'h001;
    decoder_violation <= viol_en && !rst;
  end
endmodule

// ### cell_packet_payload_mapping_bench.sv
// Purpose: self-checking bench of the payload mapping block
// Assumes: register layout and codes of payload_map_pkg
// Notes: the status word is the main window on the mapping state

`timescale 1ns/100ps

module cell_packet_payload_mapping_bench;
  import payload_map_pkg::*;
  logic clk = 1'b0;
  logic rst = 1'b1;
  axil_req_s req = '0;
  axil_rsp_s rsp;
  logic [10:0] idx;
  logic viol;
  logic viol_en = 1'b0;
  logic pin = 1'b0;
  align_e cam;
  logic ohf;
  logic ohv;
  int errors = 0;
  int n_compared = 0;
  int cyc = 0;
  logic [31:0] d;
  logic [1:0] r;
  // ----------------------------------------------------------------
  // mode table: port_control_one, port_control_two, line control, status
  // ----------------------------------------------------------------
  localparam logic [47:0] MODES [23] = '{
    48'h000_000_000_005, 48'h001_000_000_000, 48'h002_000_000_000, 48'h000_008_000_005,
    48'h000_004_000_107, 48'h001_00C_000_107, 48'h002_004_000_200, 48'h004_008_000_200,
    48'h004_00C_000_200, 48'h000_010_000_050, 48'h002_010_000_050, 48'h001_014_000_15B,
    48'h002_014_000_200, 48'h000_018_000_05A, 48'h001_018_000_050, 48'h002_018_000_050,
    48'h000_000_003_0A5, 48'h000_100_000_0F5, 48'h000_110_003_0F0, 48'h000_010_001_060,
    48'h000_028_000_000, 48'h000_030_000_050, 48'h000_123_000_0FA};

  always #2.5 clk = ~clk;

  framer_model frm_u (.clk(clk), .rst(rst), .viol_en(viol_en), .frame_bit_index(idx),
    .decoder_violation(viol));
  cell_packet_payload_mapping dut_u (.clk(clk), .rst(rst), .axil_req(req), .axil_rsp(rsp),
    .frame_bit_index(idx), .decoder_violation(viol), .rx_negative_rail_pin(pin),
    .cell_align_mode(cam), .plcp_frame_align(), .plcp_active(), .tx_line_code(),
    .rx_line_code(), .overhead_force(ohf), .overhead_value(ohv), .config_error());

  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    n_compared++;
    if (got !== exp)
    begin
      errors++;
      $display("ERROR %0t got %h expected %h", $time, got, exp);
    end
  endtask

  // bus master: ready sampled at the edge, released right after it
  task automatic wr(input logic [7:0] a, input logic [31:0] v);
    @(posedge clk);
    req.awaddr <= a;
    req.wdata <= v;
    req.wstrb <= 4'hF;
    req.awvalid <= 1'b1;
    req.wvalid <= 1'b1;
    req.bready <= 1'b1;
    do
    begin
      @(posedge clk);
      if (rsp.awready)
        req.awvalid <= 1'b0;
      if (rsp.wready)
        req.wvalid <= 1'b0;
    end while (!rsp.bvalid);
    r = rsp.bresp;
    req.bready <= 1'b0;
  endtask

  task automatic rd(input logic [7:0] a);
    @(posedge clk);
    req.araddr <= a;
    req.arvalid <= 1'b1;
    req.rready <= 1'b1;
    do
    begin
      @(posedge clk);
      if (rsp.arready)
        req.arvalid <= 1'b0;
    end while (!rsp.rvalid);
    d = rsp.rdata;
    r = rsp.rresp;
    req.rready <= 1'b0;
  endtask

  task automatic t_reset;
    rd(OFS_PORT_CONTROL_ONE);
    chk(d, 32'h0);
    rd(OFS_MAP_STATUS);
    chk(d, 32'h5);
    rd(8'h20);
    chk({30'h0, r}, {30'h0, RESP_SLVERR});
    wr(8'h20, 32'h0);
    chk({30'h0, r}, {30'h0, RESP_SLVERR});
  endtask

  task automatic t_modes;
    logic [47:0] e;
    foreach (MODES[i])
    begin
      e = MODES[i];
      wr(OFS_PORT_CONTROL_ONE, {20'h0, e[47:36]});
      wr(OFS_PORT_CONTROL_TWO, {20'h0, e[35:24]});
      wr(OFS_LINE_CONTROL, {20'h0, e[23:12]});
      rd(OFS_MAP_STATUS);
      chk(d & (e[9] ? 32'h200 : 32'hFFFFFFFF), {20'h0, e[11:0]});
      if (!e[9])
        chk({30'h0, cam}, {30'h0, e[1:0]});
    end
  endtask

  // overhead for a bit shows one cycle after its index
  task automatic t_over(input logic [3:0] p);
    int n;
    n = 0;
    @(negedge clk);
    while (idx !== 11'h00D && n < 100)
    begin
      @(negedge clk);
      n++;
    end
    for (int i = 3; i >= 0; i--)
    begin
      @(negedge clk);
      chk({30'h0, ohf, ohv}, {30'h0, 1'b1, p[i]});
    end
    @(negedge clk);
    chk({31'h0, ohf}, 32'h0);
  endtask

  task automatic t_oh;
    wr(OFS_PORT_CONTROL_ONE, 32'h0);
    wr(OFS_PORT_CONTROL_TWO, 32'h14);
    t_over(PLCP_E3_PATTERN);
    wr(OFS_PORT_CONTROL_TWO, 32'h12);
    wr(OFS_FRACTION_SECTION_A, 32'h401);
    wr(OFS_FRACTION_GROUP, 32'h5F4);
    for (int k = 0; k < 3; k++)
    begin
      wr(OFS_OVERHEAD_PATTERN, 32'(k));
      t_over(k == 0 ? ONES_PATTERN : k == 1 ? ZEROS_PATTERN : ALT_PATTERN);
    end
    rd(OFS_MAP_STATUS);
    chk(d, 32'h50);
  endtask

  task automatic t_cnt(input logic [31:0] c2, input int np, input int nv, input int exp);
    wr(OFS_PORT_CONTROL_TWO, c2);
    wr(OFS_VIOLATION_COUNT, 32'h0);
    repeat (np)
    begin
      pin <= 1'b1;
      repeat (4) @(posedge clk);
      pin <= 1'b0;
      repeat (4) @(posedge clk);
    end
    if (nv > 0)
    begin
      viol_en <= 1'b1;
      repeat (nv) @(posedge clk);
      viol_en <= 1'b0;
    end
    repeat (8) @(posedge clk);
    rd(OFS_VIOLATION_COUNT);
    chk(d, 32'(exp));
  endtask

  task automatic end_sim;
    $display("compared %0d mismatches %0d", n_compared, errors);
    if (errors == 0 && n_compared > 0)
      $display("NO MISMATCHES");
    else
      $display("MISMATCHES SEEN");
    $finish;
  endtask

  // hang guard, well above the fewer than one thousand cycles the run needs
  always @(posedge clk)
  begin
    cyc++;
    if (cyc == 8000)
    begin
      errors++;
      end_sim;
    end
  end

  initial
  begin
    repeat (16) @(posedge clk);
    rst <= 1'b0;
    t_reset;
    t_modes;
    t_oh;
    t_cnt(32'h100, 3, 0, 3);
    t_cnt(32'h101, 3, 0, 0);
    t_cnt(32'h105, 3, 0, 0);
    t_cnt(32'h123, 3, 0, 0);
    t_cnt(32'h0, 0, 5, 5);
    end_sim;
  end
endmodule
